/* hw/alr_regs.sv */
/*
  Active line length and test pattern vertical size register bank,
  an AHB-Lite slave with zero wait states.
  Assumes a single master, whole-word single transfers, and that hclk
  drives all bus signals so no input synchronisers are needed.
*/
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1 - Status update flag clears on write of one; no write-only locations exist.
// RULE2 - Single input: channel A length sets pixels per line; high nibble bits 3:0.
// RULE3 - Odd/even: channel A counts odd pixels, to output A or both outputs.
// RULE4 - Left/right: channel A counts left-half pixels sent to output A.
// RULE5 - Two streams: channel A gives pixels per line of stream A.
// RULE6 - Software programs channel A length net of the first-half trim.
// RULE7 - Single input: channel B length is ignored entirely.
// RULE8 - Odd/even: channel B counts even pixels arriving on input B.
// RULE9 - Left/right: channel B counts right-half pixels sent to output B.
// RULE10 - Two streams: channel B gives pixels per line of stream B.
// RULE11 - Channel B length: low byte bits 7:0, next register bits 3:0.
// RULE12 - Software programs channel B length net of the second-half trim.
// RULE13 - Pattern generator vertical size is 12 bits, low byte then nibble.
// RULE14 - Channel A low byte sits in the register just before its high nibble.
// RULE15 - All lengths reset to zero; unused high bits read zero, ignore writes.
module alr_regs
  import alr_pkg::*;
(
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic                 hready,
  input  wire logic [31:0]          hwdata,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic      [ALR_LEN_W-1:0] in_a_line_len,
  output logic      [ALR_LEN_W-1:0] in_b_line_len,
  output logic      [ALR_LEN_W-1:0] out_a_line_len,
  output logic      [ALR_LEN_W-1:0] out_b_line_len,
  output logic                      out_b_enable,
  output logic      [ALR_TOT_W-1:0] total_line_len,
  output logic      [ALR_LEN_W-1:0] pattern_vert_size,
  output alr_mode_t                 arrangement,
  output logic                      single_link
);

  alr_state_t           st_r;
  alr_state_t           st_nxt;
  logic                 addr_valid;
  logic [7:0]           addr_idx;
  logic [7:0]           wbyte;
  logic                 wr_a_lo;
  logic                 wr_a_hi;
  logic                 wr_b_lo;
  logic                 wr_b_hi;
  logic                 wr_v_lo;
  logic                 wr_v_hi;
  logic                 wr_arr;
  logic                 wr_stat;
  logic                 len_written;
  logic [ALR_LEN_W-1:0] a_len;
  logic [ALR_LEN_W-1:0] b_len;
  logic [ALR_LEN_W-1:0] rt_in_a;
  logic [ALR_LEN_W-1:0] rt_in_b;
  logic [ALR_LEN_W-1:0] rt_out_a;
  logic [ALR_LEN_W-1:0] rt_out_b;
  logic                 rt_out_b_on;
  logic [ALR_TOT_W-1:0] rt_total;
  logic [7:0]           rd_byte;

  // Address phase qualification
  assign addr_valid = hsel & hready & htrans[1];
  assign addr_idx   = haddr[9:2];
  assign wbyte      = hwdata[7:0];

  // Data phase write strobes
  assign wr_a_lo = st_r.wr_pend & (st_r.idx == ALR_IDX_A_LO);
  assign wr_a_hi = st_r.wr_pend & (st_r.idx == ALR_IDX_A_HI);
  assign wr_b_lo = st_r.wr_pend & (st_r.idx == ALR_IDX_B_LO);
  assign wr_b_hi = st_r.wr_pend & (st_r.idx == ALR_IDX_B_HI);
  assign wr_v_lo = st_r.wr_pend & (st_r.idx == ALR_IDX_V_LO);
  assign wr_v_hi = st_r.wr_pend & (st_r.idx == ALR_IDX_V_HI);
  assign wr_arr  = st_r.wr_pend & (st_r.idx == ALR_IDX_ARRANGE);
  assign wr_stat = st_r.wr_pend & (st_r.idx == ALR_IDX_STATUS);

  assign len_written = wr_a_lo | wr_a_hi | wr_b_lo | wr_b_hi | wr_v_lo | wr_v_hi;

  // Twelve-bit quantities from low byte and high nibble
  assign a_len = {st_r.a_hi, st_r.a_lo}; // RULE14
  assign b_len = {st_r.b_hi, st_r.b_lo}; // RULE11

  alr_route u_route (
    .mode        (st_r.mode),
    .single_link (st_r.single_link),
    .a_len       (a_len),
    .b_len       (b_len),
    .in_a_len    (rt_in_a),
    .in_b_len    (rt_in_b),
    .out_a_len   (rt_out_a),
    .out_b_len   (rt_out_b),
    .out_b_on    (rt_out_b_on),
    .total_len   (rt_total)
  );

  always_comb begin
    st_nxt = st_r;

    // Capture address phase
    st_nxt.wr_pend = addr_valid & hwrite;
    st_nxt.rd_pend = addr_valid & ~hwrite;
    if (addr_valid) begin
      st_nxt.idx = addr_idx;
    end

    // Register writes
    if (wr_a_lo) begin
      st_nxt.a_lo = wbyte; // RULE14
    end
    if (wr_a_hi) begin
      st_nxt.a_hi = wbyte[3:0]; // RULE2
    end
    if (wr_b_lo) begin
      st_nxt.b_lo = wbyte; // RULE11
    end
    if (wr_b_hi) begin
      st_nxt.b_hi = wbyte[3:0]; // RULE11
    end
    if (wr_v_lo) begin
      st_nxt.v_lo = wbyte; // RULE13
    end
    if (wr_v_hi) begin
      st_nxt.v_hi = wbyte[3:0]; // RULE13
    end
    if (wr_arr) begin
      st_nxt.mode        = alr_mode_t'(wbyte[ALR_ARR_MODE_LSB +: 2]);
      st_nxt.single_link = wbyte[ALR_ARR_LINK_BIT];
    end

    // Update flag: a new length write wins over a clear
    if (len_written) begin
      st_nxt.updated = 1'b1; // RULE1
    end else if (wr_stat && wbyte[ALR_STAT_UPD_BIT]) begin
      st_nxt.updated = 1'b0; // RULE1
    end

    // Registered arrangement results
    st_nxt.in_a_len  = rt_in_a;
    st_nxt.in_b_len  = rt_in_b; // RULE7
    st_nxt.out_a_len = rt_out_a; // RULE3
    st_nxt.out_b_len = rt_out_b;
    st_nxt.out_b_on  = rt_out_b_on;
    st_nxt.total_len = rt_total;
    st_nxt.vert_size = {st_r.v_hi, st_r.v_lo}; // RULE13
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r.wr_pend     <= 1'b0;
      st_r.rd_pend     <= 1'b0;
      st_r.idx         <= ALR_RST_INDEX;
      st_r.a_lo        <= ALR_RST_BYTE; // RULE15
      st_r.a_hi        <= ALR_RST_BYTE[3:0]; // RULE15
      st_r.b_lo        <= ALR_RST_BYTE; // RULE15
      st_r.b_hi        <= ALR_RST_BYTE[3:0]; // RULE15
      st_r.v_lo        <= ALR_RST_BYTE; // RULE15
      st_r.v_hi        <= ALR_RST_BYTE[3:0]; // RULE15
      st_r.mode        <= alr_mode_t'(ALR_RST_ARRANGE[ALR_ARR_MODE_LSB +: 2]);
      st_r.single_link <= ALR_RST_ARRANGE[ALR_ARR_LINK_BIT];
      st_r.updated     <= 1'b0;
      st_r.in_a_len    <= '0;
      st_r.in_b_len    <= '0;
      st_r.out_a_len   <= '0;
      st_r.out_b_len   <= '0;
      st_r.out_b_on    <= 1'b0;
      st_r.total_len   <= '0;
      st_r.vert_size   <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Read data mux; high nibbles pad with zero, unmapped reads zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (st_r.idx)
      ALR_IDX_A_LO:     rd_byte = st_r.a_lo;
      ALR_IDX_A_HI:     rd_byte = {4'h0, st_r.a_hi} & ALR_HI_MASK; // RULE15
      ALR_IDX_B_LO:     rd_byte = st_r.b_lo;
      ALR_IDX_B_HI:     rd_byte = {4'h0, st_r.b_hi} & ALR_HI_MASK; // RULE15
      ALR_IDX_V_LO:     rd_byte = st_r.v_lo;
      ALR_IDX_V_HI:     rd_byte = {4'h0, st_r.v_hi} & ALR_HI_MASK; // RULE15
      ALR_IDX_ARRANGE:  rd_byte = {5'h00, st_r.single_link, st_r.mode} & ALR_ARR_MASK;
      ALR_IDX_STATUS:   rd_byte = {7'h00, st_r.updated};
      ALR_IDX_TOTAL_LO: rd_byte = st_r.total_len[7:0];
      ALR_IDX_TOTAL_HI: rd_byte = {3'h0, st_r.total_len[12:8]};
      default:          rd_byte = 8'h00;
    endcase
  end

  assign hrdata    = st_r.rd_pend ? {24'h000000, rd_byte} : 32'h00000000;
  assign hreadyout = 1'b1;
  assign hresp     = ALR_HRESP_OKAY;

  // Datapath outputs straight from state
  assign in_a_line_len     = st_r.in_a_len; // RULE2
  assign in_b_line_len     = st_r.in_b_len; // RULE8
  assign out_a_line_len    = st_r.out_a_len; // RULE4
  assign out_b_line_len    = st_r.out_b_len; // RULE9
  assign out_b_enable      = st_r.out_b_on;
  assign total_line_len    = st_r.total_len; // RULE5
  assign pattern_vert_size = st_r.vert_size; // RULE13
  assign arrangement       = st_r.mode;
  assign single_link       = st_r.single_link;

endmodule : alr_regs
`default_nettype wire

/* hw/alr_pkg.sv */
/*
  Constants and types for the active line length register bank.
  Assumes a 32-bit AHB-Lite bus with one aligned word per register.
*/
package alr_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] ALR_IDX_A_LO     = 8'h20;
  localparam logic [7:0] ALR_IDX_A_HI     = 8'h21;
  localparam logic [7:0] ALR_IDX_B_LO     = 8'h22;
  localparam logic [7:0] ALR_IDX_B_HI     = 8'h23;
  localparam logic [7:0] ALR_IDX_V_LO     = 8'h24;
  localparam logic [7:0] ALR_IDX_V_HI     = 8'h25;
  localparam logic [7:0] ALR_IDX_ARRANGE  = 8'h30;
  localparam logic [7:0] ALR_IDX_STATUS   = 8'h31;
  localparam logic [7:0] ALR_IDX_TOTAL_LO = 8'h32;
  localparam logic [7:0] ALR_IDX_TOTAL_HI = 8'h33;

  // Field layout
  localparam int         ALR_LEN_W        = 12;
  localparam int         ALR_TOT_W        = 13;
  localparam logic [7:0] ALR_HI_MASK      = 8'h0F;
  localparam int         ALR_ARR_MODE_LSB = 0;
  localparam int         ALR_ARR_LINK_BIT = 2;
  localparam logic [7:0] ALR_ARR_MASK     = 8'h07;
  localparam int         ALR_STAT_UPD_BIT = 0;

  // Reset values
  localparam logic [7:0] ALR_RST_BYTE     = 8'h00;
  localparam logic [7:0] ALR_RST_ARRANGE  = 8'h00;
  localparam logic [7:0] ALR_RST_INDEX    = 8'h00;

  // Bus encodings
  localparam logic [1:0] ALR_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] ALR_HTRANS_SEQ    = 2'h3;
  localparam logic       ALR_HRESP_OKAY    = 1'h0;

  typedef enum logic [1:0] {
    ALR_SINGLE,
    ALR_ODD_EVEN,
    ALR_LEFT_RIGHT,
    ALR_TWO_STREAM
  } alr_mode_t;

  typedef struct packed {
    logic                 wr_pend;
    logic                 rd_pend;
    logic [7:0]           idx;
    logic [7:0]           a_lo;
    logic [3:0]           a_hi;
    logic [7:0]           b_lo;
    logic [3:0]           b_hi;
    logic [7:0]           v_lo;
    logic [3:0]           v_hi;
    alr_mode_t            mode;
    logic                 single_link;
    logic                 updated;
    logic [ALR_LEN_W-1:0] in_a_len;
    logic [ALR_LEN_W-1:0] in_b_len;
    logic [ALR_LEN_W-1:0] out_a_len;
    logic [ALR_LEN_W-1:0] out_b_len;
    logic                 out_b_on;
    logic [ALR_TOT_W-1:0] total_len;
    logic [ALR_LEN_W-1:0] vert_size;
  } alr_state_t;

endpackage : alr_pkg

/* hw/alr_route.sv */
/*
  Arrangement decoder: maps the two stored line lengths onto inputs
  and outputs. Purely combinational; the caller registers the results.
*/
`timescale 1ns/1ps
`default_nettype none
module alr_route
  import alr_pkg::*;
(
  input  wire alr_mode_t            mode,
  input  wire logic                 single_link,
  input  wire logic [ALR_LEN_W-1:0] a_len,
  input  wire logic [ALR_LEN_W-1:0] b_len,
  output logic      [ALR_LEN_W-1:0] in_a_len,
  output logic      [ALR_LEN_W-1:0] in_b_len,
  output logic      [ALR_LEN_W-1:0] out_a_len,
  output logic      [ALR_LEN_W-1:0] out_b_len,
  output logic                      out_b_on,
  output logic      [ALR_TOT_W-1:0] total_len
);

  logic [ALR_TOT_W-1:0] sum_ab;

  assign sum_ab = {1'b0, a_len} + {1'b0, b_len};

  always_comb begin
    in_a_len  = a_len;
    in_b_len  = '0;
    out_a_len = a_len;
    out_b_len = '0;
    out_b_on  = 1'b0;
    total_len = {1'b0, a_len};
    unique case (mode)
      ALR_SINGLE: begin
        in_b_len  = '0; // RULE7
        out_b_on  = ~single_link;
        out_b_len = single_link ? '0 : a_len; // RULE2
        total_len = {1'b0, a_len}; // RULE2
      end
      ALR_ODD_EVEN: begin
        in_b_len  = b_len; // RULE8
        out_b_on  = ~single_link;
        out_b_len = single_link ? '0 : a_len; // RULE3
        total_len = sum_ab;
      end
      ALR_LEFT_RIGHT: begin
        in_b_len  = b_len; // RULE9
        out_b_on  = 1'b1;
        out_b_len = b_len; // RULE9
        total_len = sum_ab; // RULE4
      end
      ALR_TWO_STREAM: begin
        in_b_len  = b_len; // RULE10
        out_b_on  = 1'b1;
        out_b_len = b_len; // RULE10
        total_len = {1'b0, a_len}; // RULE5
      end
    endcase
  end

endmodule : alr_route
`default_nettype wire

/* verification/alr_regs_props.sv */
/*
  Checker for the line length register bank.
  Sees only the bank's ports; attached by the bind after the module.
*/
`timescale 1ns/1ps
`default_nettype none
module alr_regs_props
  import alr_pkg::*;
(
  input wire logic                 hclk,
  input wire logic                 hresetn,
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic                 hready,
  input wire logic [31:0]          hwdata,
  input wire logic [31:0]          hrdata,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire logic [ALR_LEN_W-1:0] in_a_line_len,
  input wire logic [ALR_LEN_W-1:0] in_b_line_len,
  input wire logic [ALR_LEN_W-1:0] out_a_line_len,
  input wire logic [ALR_LEN_W-1:0] out_b_line_len,
  input wire logic                 out_b_enable,
  input wire logic [ALR_TOT_W-1:0] total_line_len,
  input wire logic [ALR_LEN_W-1:0] pattern_vert_size,
  input wire alr_mode_t            arrangement,
  input wire logic                 single_link
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  wire take = hsel && hready && htrans[1];
  wire wr = take && hwrite;
  wire rd_any = take && !hwrite;
  wire rd_hi = rd_any && haddr[9:2] inside {ALR_IDX_A_HI, ALR_IDX_B_HI, ALR_IDX_V_HI};
  property p_ok; hreadyout && hresp == ALR_HRESP_OKAY; endproperty
  a_ok: assert property (p_ok) else $error("bus answer not ready or okay");
  property p_idle; !$past(rd_any) |-> hrdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside data phase");
  property p_hi; $past(rd_hi) |-> hrdata[31:4] == 28'h0; endproperty
  a_hi: assert property (p_hi) else $error("high nibble reg upper bits set");
  property p_alo;
    wr && haddr[9:2] == ALR_IDX_A_LO |-> ##3 in_a_line_len[7:0] == 8'($past(hwdata, 2));
  endproperty
  a_alo: assert property (p_alo) else $error("chan a low byte wrong");
  property p_ahi;
    wr && haddr[9:2] == ALR_IDX_A_HI |-> ##3 in_a_line_len[11:8] == 4'($past(hwdata, 2));
  endproperty
  a_ahi: assert property (p_ahi) else $error("chan a high nibble wrong");
  property p_v;
    wr && haddr[9:2] == ALR_IDX_V_LO |-> ##3 pattern_vert_size[7:0] == 8'($past(hwdata, 2));
  endproperty
  a_v: assert property (p_v) else $error("vert size low byte wrong");
  property p_oa; out_a_line_len == in_a_line_len; endproperty
  a_oa: assert property (p_oa) else $error("output a length differs");
  property p_sg;
    arrangement == ALR_SINGLE && $stable(arrangement) |-> in_b_line_len == 12'h0;
  endproperty
  a_sg: assert property (p_sg) else $error("chan b used in single mode");
  property p_oe;
    arrangement == ALR_ODD_EVEN && $stable(arrangement)
      |-> total_line_len == in_a_line_len + in_b_line_len;
  endproperty
  a_oe: assert property (p_oe) else $error("odd even total wrong");
  property p_lr;
    arrangement == ALR_LEFT_RIGHT && $stable(arrangement)
      |-> out_b_enable && out_b_line_len == in_b_line_len;
  endproperty
  a_lr: assert property (p_lr) else $error("left right output b wrong");
  property p_ts;
    arrangement == ALR_TWO_STREAM && $stable(arrangement)
      |-> out_b_enable && total_line_len == in_a_line_len;
  endproperty
  a_ts: assert property (p_ts) else $error("two stream output wrong");
  // Registered enable lags one cycle after reset release
  property p_lk;
    $past(hresetn) && arrangement inside {ALR_SINGLE, ALR_ODD_EVEN} && $stable(arrangement)
      && $stable(single_link) |-> out_b_enable == !single_link;
  endproperty
  a_lk: assert property (p_lk) else $error("output b enable wrong");
endmodule : alr_regs_props
bind alr_regs alr_regs_props u_props (.*);
`default_nettype wire

/* verification/alr_regs_tb.sv */
/*
  Self-checking bench for the line length register bank.
  Drives AHB-Lite single word transfers; hready follows hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none
module alr_regs_tb
  import alr_pkg::*;
;
  logic                 hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]          haddr, hwdata, hrdata, q;
  logic [1:0]           htrans;
  logic [2:0]           hsize;
  wire logic            hready;
  logic [ALR_LEN_W-1:0] in_a_line_len, in_b_line_len, out_a_line_len;
  logic [ALR_LEN_W-1:0] out_b_line_len, pattern_vert_size;
  logic [ALR_TOT_W-1:0] total_line_len, eb, ob, tot;
  logic                 out_b_enable, single_link, en;
  alr_mode_t            arrangement;
  int                   err_total, num_checks;
  logic [7:0]           val [6] = '{8'h23, 8'hF1, 8'h56, 8'hF4, 8'h9A, 8'hFB};
  assign hready = hreadyout;
  alr_regs u_dut (.*);
  initial begin
    hclk = 1'h0;
    forever #20 hclk = ~hclk;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wait_rdy;
    int n;
    n = 0;
    // Ready sampled at the rising edge that ends the phase
    @(posedge hclk);
    while (hready !== 1'h1) begin
      n++;
      if (n > 50) begin
        err_total++;
        give_verdict;
      end
      @(posedge hclk);
    end
  endtask : wait_rdy
  task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d);
    hsel   <= 1'h1;
    htrans <= ALR_HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= {22'h0, i, 2'h0};
    wait_rdy;
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
  endtask : xfer
  task automatic rd(input logic [7:0] i, input logic [31:0] e, input string nm);
    xfer(1'h0, i, 32'h0);
    chk(nm, q, e);
  endtask : rd
  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    for (int k = 0; k < 6; k++) rd(8'(ALR_IDX_A_LO + k), 32'h0, "reset value");
    chk("vert reset", 32'(pattern_vert_size), 32'h0);
    $display("test reset done");
    for (int k = 0; k < 6; k++) begin
      xfer(1'h1, 8'(ALR_IDX_A_LO + k), {24'hFFFFFF, val[k]});
    end
    for (int k = 0; k < 6; k++) begin
      rd(8'(ALR_IDX_A_LO + k), 32'(val[k] & (k[0] ? ALR_HI_MASK : 8'hFF)),
         "readback");
    end
    chk("vert size", 32'(pattern_vert_size), 32'hB9A);
    xfer(1'h1, 8'h2F, 32'hFFFFFFFF);
    rd(8'h2F, 32'h0, "unmapped");
    xfer(1'h0, ALR_IDX_STATUS, 32'h0);
    chk("status set", 32'(q[0]), 32'h1);
    xfer(1'h1, ALR_IDX_STATUS, 32'h1);
    xfer(1'h0, ALR_IDX_STATUS, 32'h0);
    chk("status clear", 32'(q[0]), 32'h0);
    $display("test access done");
    for (int m = 0; m < 8; m++) begin
      xfer(1'h1, ALR_IDX_ARRANGE, 32'(m));
      repeat (3) @(posedge hclk);
      eb = (m[1:0] == 2'h0) ? 13'h0 : 13'h456;
      en = m[1] | ~m[2];
      ob = m[1] ? 13'h456 : (m[2] ? 13'h0 : 13'h123);
      tot = (m[1:0] == 2'h1 || m[1:0] == 2'h2) ? 13'h579 : 13'h123;
      chk("in a", 32'(in_a_line_len), 32'h123);
      chk("out a", 32'(out_a_line_len), 32'h123);
      chk("in b", 32'(in_b_line_len), 32'(eb));
      chk("out b", 32'(out_b_line_len), 32'(ob));
      chk("out b on", 32'(out_b_enable), 32'(en));
      chk("total", 32'(total_line_len), 32'(tot));
      chk("mode", 32'(arrangement), 32'(m[1:0]));
      chk("link", 32'(single_link), 32'(m[2]));
      rd(ALR_IDX_TOTAL_LO, 32'(tot[7:0]), "total lo");
      rd(ALR_IDX_ARRANGE, 32'(m), "arrange");
    end
    $display("test modes done");
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rd(ALR_IDX_A_LO, 32'h0, "second reset");
    chk("total reset", 32'(total_line_len), 32'h0);
    $display("test second reset done");
    give_verdict;
  end
endmodule : alr_regs_tb
`default_nettype wire
